// file: logic/barrel_shifter.sv
// combinational barrel shifter covering all shift kinds and special amounts
`timescale 1ns/1ps
module barrel_shifter (
  // request
  input  wire opshift_pkg::shift_req_t req,
  // answer
  output opshift_pkg::shift_res_t     res
);
  import opshift_pkg::*;

  // ==========================================================
  // shift evaluation
  // amounts above 32 fold early so the 64-bit arithmetic stays small
  always_comb begin
    logic [63:0] wide;
    logic [4:0]  fld;
    logic [5:0]  n;
    logic [7:0]  amt;
    wide = 64'h0;
    fld  = req.amount[4:0];
    n    = 6'h0;
    amt  = req.amount;
    res.value = req.value;
    res.carry = req.carry_in;
    if (req.immediate) begin
      // rotate by twice the rotate field, carried in amount
      wide = {req.value, req.value} >> amt[4:0];
      res.value = wide[31:0];
      res.carry = (amt == AMT_ZERO) ? req.carry_in : wide[31];
    end else if (!req.from_register) begin
      // instruction field: 0 to 31, zero has special meaning per kind
      case (shift_kind_t'(req.kind))
        SH_LSL: begin
          if (fld != FLD_ZERO) begin
            wide = {32'h0, req.value} << fld;
            res.value = wide[31:0];
            res.carry = wide[32];
          end
        end
        SH_LSR: begin
          if (fld == FLD_ZERO) begin
            res.value = 32'h0;
            res.carry = req.value[31];
          end else begin
            wide = {req.value, 32'h0} >> fld;
            res.value = wide[63:32];
            res.carry = wide[31];
          end
        end
        SH_ASR: begin
          if (fld == FLD_ZERO) begin
            res.value = {32{req.value[31]}};
            res.carry = req.value[31];
          end else begin
            wide = 64'($signed({req.value, 32'h0}) >>> fld);
            res.value = wide[63:32];
            res.carry = wide[31];
          end
        end
        SH_ROR: begin
          if (fld == FLD_ZERO) begin
            res.value = {req.carry_in, req.value[31:1]};
            res.carry = req.value[0];
          end else begin
            wide = {req.value, req.value} >> fld;
            res.value = wide[31:0];
            res.carry = wide[31];
          end
        end
        default: begin
          res.value = req.value;
          res.carry = req.carry_in;
        end
      endcase
    end else if (amt != AMT_ZERO) begin
      // register amount: low byte only, 1..31 same as field form
      n = (amt > AMT_WORD) ? 6'h21 : amt[5:0];
      case (shift_kind_t'(req.kind))
        SH_LSL: begin
          wide = {32'h0, req.value} << n;
          res.value = wide[31:0];
          res.carry = wide[32];
        end
        SH_LSR: begin
          wide = {req.value, 32'h0} >> n;
          res.value = wide[63:32];
          res.carry = wide[31];
        end
        SH_ASR: begin
          if (amt >= AMT_WORD) begin
            res.value = {32{req.value[31]}};
            res.carry = req.value[31];
          end else begin
            wide = 64'($signed({req.value, 32'h0}) >>> n);
            res.value = wide[63:32];
            res.carry = wide[31];
          end
        end
        SH_ROR: begin
          // low five bits zero means an effective rotate by 32
          wide = {req.value, req.value} >> amt[4:0];
          res.value = wide[31:0];
          res.carry = wide[31];
        end
        default: begin
          res.value = req.value;
          res.carry = req.carry_in;
        end
      endcase
    end
  end

endmodule : barrel_shifter

// file: logic/operand_shifter_datapath.sv
// data processing second-operand datapath with pc handling and cycle costing
`timescale 1ns/1ps
module operand_shifter_datapath (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // request from decode
  input  wire opshift_pkg::dp_req_t  req,
  // answer toward alu and writeback
  output opshift_pkg::dp_resp_t      resp,
  // status word for writeback
  output logic [31:0]                next_status,
  // pc value to write, low bits cleared
  output logic [31:0]                pc_value
);
  import opshift_pkg::*;

  // ==========================================================
  // state record
  typedef struct packed {
    issue_state_t st;
    logic [2:0]   remain;
    dp_resp_t     out;
    logic [31:0]  status;
    logic [31:0]  pc;
  } state_t;

  state_t cur;
  state_t next_cur;

  shift_req_t sreq;
  shift_res_t sres;

  // ==========================================================
  // decode of the instruction fields
  logic [31:0] ins;
  logic        is_imm;
  logic        is_regsh;
  logic        upd;
  logic [3:0]  opc;
  logic [3:0]  dest;
  logic [3:0]  first_num;
  logic [3:0]  src_num;
  logic [3:0]  amt_num;
  logic        is_test;
  logic        is_logical;
  logic        is_arith;
  logic        pc_dest;
  logic        old_carry;
  logic        ok;
  logic        complex_sh;
  logic [31:0] op1;
  logic [31:0] src;

  assign ins        = req.instr;
  assign is_imm     = ins[IMM_FLAG_BIT];
  assign is_regsh   = !is_imm && ins[REG_SHIFT_BIT];
  assign upd        = ins[FLAG_UPD_BIT];
  assign opc        = ins[OPC_HI:OPC_LO];
  assign dest       = ins[DEST_HI:DEST_LO];
  assign first_num  = ins[FIRST_HI:FIRST_LO];
  assign src_num    = ins[SRC_HI:SRC_LO];
  assign amt_num    = ins[AMT_REG_HI:AMT_REG_LO];
  assign old_carry  = req.current_status_register[CARRY_BIT];
  assign is_test    = (opc[3:2] == 2'h2);
  assign is_logical = (opc == OP_AND) || (opc == OP_EOR) || (opc == OP_TST)
                   || (opc == OP_TEQ) || (opc >= OP_ORR);
  assign is_arith   = !is_logical;
  assign pc_dest    = (dest == PC_REG_NUM) && !is_test;

  // validity of the encoding as a data processing instruction
  // a violating word is flagged rather than executed so the core can divert it
  always_comb begin
    ok = 1'b1;
    if (is_regsh && ins[REG_SHIFT_ZERO])
      ok = 1'b0;
    if (is_test && !upd)
      ok = 1'b0;
    if (is_regsh && (amt_num == PC_REG_NUM || src_num == PC_REG_NUM
                     || first_num == PC_REG_NUM))
      ok = 1'b0;
  end

  // pc reads as instruction address plus 8, low bits zero
  always_comb begin
    op1 = req.first_operand_register;
    src = req.shift_source_register;
    if (first_num == PC_REG_NUM)
      op1 = (req.instr_addr + PC_OFFSET) & PC_LOW_MASK;
    if (!is_imm && src_num == PC_REG_NUM)
      src = (req.instr_addr + PC_OFFSET) & PC_LOW_MASK;
  end

  // ==========================================================
  // shifter request
  always_comb begin
    sreq.value         = src;
    sreq.amount        = {3'h0, ins[AMT_FLD_HI:AMT_FLD_LO]};
    sreq.kind          = ins[SHTYPE_HI:SHTYPE_LO];
    sreq.carry_in      = old_carry;
    sreq.from_register = is_regsh;
    sreq.immediate     = is_imm;
    if (is_imm) begin
      sreq.value  = {24'h0, ins[IMMB_HI:IMMB_LO]};
      sreq.amount = {3'h0, ins[ROT_HI:ROT_LO], 1'b0};
    end else if (is_regsh) begin
      sreq.amount = req.shift_amount_register[7:0];
    end
  end

  barrel_shifter u_shift (
    .req (sreq),
    .res (sres)
  );

  // anything but a field-form left shift of 0..3 or an unrotated immediate costs arithmetic ops one cycle
  always_comb begin
    complex_sh = 1'b0;
    if (is_imm)
      complex_sh = (ins[ROT_HI:ROT_LO] != 4'h0);
    else if (is_regsh)
      complex_sh = 1'b1;
    else if (shift_kind_t'(ins[SHTYPE_HI:SHTYPE_LO]) != SH_LSL)
      complex_sh = 1'b1;
    else
      complex_sh = (ins[AMT_FLD_HI:AMT_FLD_LO] > FAST_LSL_MAX);
  end

  // ==========================================================
  // next state: one issue per instruction, busy for its cycle cost
  always_comb begin
    logic [2:0] cost;
    cost     = CYC_BASE;
    next_cur = cur;
    next_cur.out.valid = 1'b0;
    if (is_arith && complex_sh)
      cost = cost + CYC_COMPLEX;
    if (is_regsh)
      cost = cost + CYC_REGSHIFT;
    if (pc_dest)
      cost = cost + (upd ? CYC_PC_FLAGS : CYC_PC_PLAIN);
    case (cur.st)
      ST_IDLE: begin
        if (req.valid) begin
          next_cur.out.decode_ok      = ok;
          next_cur.out.opcode         = opc;
          next_cur.out.operand1       = op1;
          next_cur.out.operand2       = sres.value;
          next_cur.out.shifter_carry  = sres.carry;
          next_cur.out.write_result   = ok && !is_test;
          next_cur.out.pc_write       = ok && pc_dest;
          next_cur.out.status_restore = ok && pc_dest && upd;
          next_cur.out.load_carry     = ok && is_logical && upd && !pc_dest;
          next_cur.out.cycles         = cost;
          next_cur.status             = req.current_status_register;
          if (ok && pc_dest && upd)
            next_cur.status = req.saved_status_register;
          else if (ok && is_logical && upd && !pc_dest)
            next_cur.status[CARRY_BIT] = sres.carry;
          // pc writes drop the two low bits
          next_cur.pc = sres.value & PC_LOW_MASK;
          if (cost == CYC_BASE) begin
            next_cur.out.valid = 1'b1;
          end else begin
            next_cur.st     = ST_BUSY;
            next_cur.remain = cost - 3'h1;
          end
        end
      end
      ST_BUSY: begin
        // request input is ignored until the cost has elapsed
        next_cur.remain = cur.remain - 3'h1;
        if (cur.remain == 3'h1) begin
          next_cur.st        = ST_IDLE;
          next_cur.out.valid = 1'b1;
        end
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (srst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign resp        = cur.out;
  assign next_status = cur.status;
  assign pc_value    = cur.pc;

endmodule : operand_shifter_datapath

// file: logic/opshift_pkg.sv
// constants and carrier types for the operand shifter datapath
//
// Behaviour
// - instruction shift amount is an unsigned 5-bit field, 0 to 31
// - left shift zero-fills low bits; carry is lowest bit shifted out
// - instruction left shift by zero passes source, carry is old carry flag
// - instruction right shift field zero means shift by 32: zero, carry bit 31
// - arithmetic shift fills with bit 31; field zero means 32, carry bit 31
// - rotate right reinserts low bits shifted out at the high end
// - instruction rotate field zero performs rotate_extended through carry flag
// - register shifts use only low byte of amount register, never program counter
// - register amount zero passes source unchanged with old carry flag
// - register amounts 1 to 31 match instruction shifts exactly
// - register logical shift 32 gives zero, edge carry; beyond 32 zero carry
// - register arithmetic shift of 32 or more gives all bit 31, carry bit 31
// - register rotate by 32 returns source, carry bit 31; larger wraps modulo 32
// - register shift encoding valid only when bit 7 is zero
// - immediate byte zero-extended, rotated right by twice rotate field
// - immediate carry is old carry when rotate zero, else result bit 31
// - program counter destination without flag update leaves status unchanged
// - program counter destination with flag update copies saved status to current
// - program counter low two bits read as zero, ignored on write
// - program counter operand reads address plus 8; not allowed with register shift
// - test and compare opcodes need flag update bit 20 set, write no result
// - cycles: 1, +1 complex arithmetic shift, +1 register shift, +2/+3 pc write
// - logical ops with flag update, non-pc destination load shifter carry
package opshift_pkg;

  // instruction field positions
  localparam int IMM_FLAG_BIT   = 25;
  localparam int OPC_HI         = 24;
  localparam int OPC_LO         = 21;
  localparam int FLAG_UPD_BIT   = 20;
  localparam int FIRST_HI       = 19;
  localparam int FIRST_LO       = 16;
  localparam int DEST_HI        = 15;
  localparam int DEST_LO        = 12;
  localparam int AMT_REG_HI     = 11;
  localparam int AMT_REG_LO     = 8;
  localparam int AMT_FLD_HI     = 11;
  localparam int AMT_FLD_LO     = 7;
  localparam int REG_SHIFT_ZERO = 7;
  localparam int SHTYPE_HI      = 6;
  localparam int SHTYPE_LO      = 5;
  localparam int REG_SHIFT_BIT  = 4;
  localparam int SRC_HI         = 3;
  localparam int SRC_LO         = 0;
  localparam int ROT_HI         = 11;
  localparam int ROT_LO         = 8;
  localparam int IMMB_HI        = 7;
  localparam int IMMB_LO        = 0;

  // status word carry position and register numbers
  localparam int          CARRY_BIT   = 29;
  localparam logic [3:0]  PC_REG_NUM  = 4'hf;
  localparam logic [31:0] PC_OFFSET   = 32'h0000_0008;
  localparam logic [31:0] PC_LOW_MASK = 32'hffff_fffc;

  // shift amount limits
  localparam logic [7:0] AMT_ZERO     = 8'h00;
  localparam logic [7:0] AMT_WORD     = 8'h20;
  localparam logic [4:0] FLD_ZERO     = 5'h00;
  localparam logic [4:0] FAST_LSL_MAX = 5'h03;

  // cycle cost increments
  localparam logic [2:0] CYC_BASE     = 3'h1;
  localparam logic [2:0] CYC_COMPLEX  = 3'h1;
  localparam logic [2:0] CYC_REGSHIFT = 3'h1;
  localparam logic [2:0] CYC_PC_PLAIN = 3'h2;
  localparam logic [2:0] CYC_PC_FLAGS = 3'h3;

  typedef enum logic [1:0] {
    SH_LSL = 2'h0,
    SH_LSR = 2'h1,
    SH_ASR = 2'h2,
    SH_ROR = 2'h3
  } shift_kind_t;

  typedef enum logic [3:0] {
    OP_AND = 4'h0, OP_EOR = 4'h1, OP_SUB = 4'h2, OP_RSB = 4'h3,
    OP_ADD = 4'h4, OP_ADC = 4'h5, OP_SBC = 4'h6, OP_RSC = 4'h7,
    OP_TST = 4'h8, OP_TEQ = 4'h9, OP_CMP = 4'ha, OP_CMN = 4'hb,
    OP_ORR = 4'hc, OP_MOV = 4'hd, OP_BIC = 4'he, OP_MVN = 4'hf
  } opcode_t;

  // pipeline issue phase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } issue_state_t;

  // request from decode: instruction word and register reads
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] instr_addr;
    logic [31:0] first_operand_register;
    logic [31:0] shift_source_register;
    logic [31:0] shift_amount_register;
    logic [31:0] current_status_register;
    logic [31:0] saved_status_register;
  } dp_req_t;

  // result toward alu and writeback
  typedef struct packed {
    logic        valid;
    logic        decode_ok;
    logic [3:0]  opcode;
    logic [31:0] operand1;
    logic [31:0] operand2;
    logic        shifter_carry;
    logic        write_result;
    logic        pc_write;
    logic        status_restore;
    logic        load_carry;
    logic [2:0]  cycles;
  } dp_resp_t;

  // shifter core request and answer
  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  amount;
    logic [1:0]  kind;
    logic        carry_in;
    logic        from_register;
    logic        immediate;
  } shift_req_t;

  typedef struct packed {
    logic [31:0] value;
    logic        carry;
  } shift_res_t;

endpackage : opshift_pkg

// file: tb/operand_shifter_datapath_tb_top.sv
// self-checking bench for the operand shifter datapath
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module operand_shifter_datapath_tb_top;
  import opshift_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  dp_req_t     req;
  dp_resp_t    resp;
  logic [31:0] next_status;
  logic [31:0] pc_value;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles_run = 0;
  logic [11:0] hd [3] = '{12'he1b, 12'he08, 12'he15};
  logic [4:0]  fl [5] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h1f};
  logic [7:0]  am [7] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'h40, 8'hff};
  logic [31:0] sp [9] = '{32'he1a0f003, 32'he1b0f123, 32'he08f110f, 32'he290f410,
                          32'he1b01063, 32'he08f1233, 32'he1b01293, 32'he080123f, 32'he1b01f13};

  operand_shifter_datapath operand_shifter_datapath_i (.clk(clk), .srst(srst), .req(req),
    .resp(resp), .next_status(next_status), .pc_value(pc_value));
  pipe_partner pipe_partner_i (.clk(clk), .req(req), .resp(resp));

  // clock and hang guard; a full run takes little more than a thousand cycles
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles_run++;
    if (cycles_run == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ===============================================
  // reference model
  function automatic logic [32:0] shf(logic [31:0] v, int a, logic [1:0] k, logic c);
    int b;
    if (a == 0) return {c, v};
    case (k)
      2'h0: return (a > 32) ? 33'h0 : {v[32 - a], v << a};
      2'h1: return (a > 32) ? 33'h0 : {v[a - 1], v >> a};
      2'h2: return (a >= 32) ? {33{v[31]}} : {v[a - 1], $signed(v) >>> a};
      default: begin
        b = (a - 1) % 32 + 1;
        return {v[b - 1], (v >> b) | (v << (32 - b))};
      end
    endcase
  endfunction : shf

  function automatic dp_resp_t model(input dp_req_t r, output logic [31:0] st);
    dp_resp_t    e;
    logic [31:0] i, pc8, src;
    logic [32:0] sr;
    logic        c, rsh, tst, lgc, cpx;
    int          a;
    i = r.instr;
    pc8 = (r.instr_addr + PC_OFFSET) & PC_LOW_MASK;
    c = r.current_status_register[CARRY_BIT];
    rsh = !i[25] && i[4];
    tst = i[24:23] == 2'b10;
    lgc = i[24:21] inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
    src = (i[3:0] == PC_REG_NUM) ? pc8 : r.shift_source_register;
    e = '0;
    e.valid = 1'b1;
    e.decode_ok = !(rsh && (i[7] || i[19:16] == 4'hf || i[3:0] == 4'hf || i[11:8] == 4'hf))
               && !(tst && !i[20]);
    e.opcode = i[24:21];
    e.operand1 = (i[19:16] == PC_REG_NUM) ? pc8 : r.first_operand_register;
    if (i[25]) begin
      a = 2 * i[11:8];
      sr[31:0] = ({24'h0, i[7:0]} >> a) | ({24'h0, i[7:0]} << (32 - a));
      sr[32] = (a == 0) ? c : sr[31];
      cpx = a != 0;
    end else if (rsh) begin
      sr = shf(src, r.shift_amount_register[7:0], i[6:5], c);
      cpx = 1'b1;
    end else begin
      a = i[11:7];
      cpx = !(i[6:5] == 2'h0 && a <= 3);
      if (a == 0 && i[6:5] == 2'h3) sr = {src[0], c, src[31:1]};
      else sr = shf(src, (a == 0 && i[6:5] != 2'h0) ? 32 : a, i[6:5], c);
    end
    e.operand2 = sr[31:0];
    e.shifter_carry = sr[32];
    e.write_result = !tst;
    e.pc_write = !tst && i[15:12] == PC_REG_NUM;
    e.status_restore = e.pc_write && i[20];
    e.load_carry = lgc && i[20] && !e.pc_write;
    e.cycles = 3'(1 + (!lgc && cpx) + rsh + (e.pc_write ? 2 + i[20] : 0));
    st = e.status_restore ? r.saved_status_register : r.current_status_register;
    if (e.load_carry) st[CARRY_BIT] = e.shifter_carry;
    return e;
  endfunction : model

  // one instruction with random register contents, checked at its answer
  task automatic run(input logic [31:0] instr, input logic [7:0] amt);
    dp_req_t     r;
    dp_resp_t    e;
    logic [31:0] st;
    int          lat;
    r.valid = 1'b1;
    r.instr = instr;
    // low address bits left random so the pc read mask is exercised
    r.instr_addr = $urandom;
    r.first_operand_register = $urandom;
    r.shift_source_register = $urandom;
    r.shift_amount_register = ($urandom & 32'hffff_ff00) | 32'(amt);
    r.current_status_register = $urandom;
    r.saved_status_register = $urandom;
    e = model(r, st);
    pipe_partner_i.issue(r, lat);
    if (e.decode_ok) begin
      `CHK(resp, e)
      `CHK(next_status, st)
      `CHK(pc_value, {e.operand2[31:2], 2'h0})
      `CHK(lat, int'(e.cycles))
    end else begin
      `CHK(resp.decode_ok, 1'b0)
    end
  endtask : run

  // ===============================================
  // scenarios
  initial begin
    logic [31:0] i;
    void'($urandom(32'hb184aadb));
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    // every shift kind at field and register boundary amounts
    foreach (hd[h]) for (int k = 0; k < 4; k++) begin
      foreach (fl[n]) run({hd[h], 8'h01, fl[n], k[1:0], 5'h03}, 8'h00);
      foreach (am[n]) run({hd[h], 12'h012, 1'b0, k[1:0], 5'h13}, am[n]);
    end
    // all rotate counts, back to back where the cost is one cycle
    for (int r = 0; r < 16; r++) run({r[0] ? 12'he28 : 12'he3b, 8'h01, r[3:0], 8'($urandom)}, 8'h00);
    foreach (sp[n]) run(sp[n], 8'($urandom));
    for (int t = 0; t < 8; t++) run({7'h70, 2'b10, t[2:1], t[0], 20'h01123}, 8'h00);
    // random legal instructions
    repeat (400) begin
      i = $urandom;
      i[31:26] = 6'h38;
      if (i[24:23] == 2'b10) i[20] = 1'b1;
      if (!i[25] && i[4]) begin
        i[7] = 1'b0;
        if (i[11:8] == 4'hf) i[8] = 1'b0;
        if (i[19:16] == 4'hf) i[16] = 1'b0;
        if (i[3:0] == 4'hf) i[0] = 1'b0;
      end
      run(i, ($urandom % 2) ? 8'($urandom % 40) : 8'($urandom));
    end
    pipe_partner_i.release_bus();
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : operand_shifter_datapath_tb_top

// file: tb/opshift_chk.sv
// port assertions for the operand shifter datapath
`timescale 1ns/1ps
module opshift_chk (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // watched ports
  input wire opshift_pkg::dp_req_t  req,
  input wire opshift_pkg::dp_resp_t resp,
  input wire logic [31:0]           next_status,
  input wire logic [31:0]           pc_value
);
  import opshift_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic        pend;
  logic        idle;
  logic [2:0]  cnt;
  logic [31:0] immv;
  dp_req_t     held;
  // ===============================================
  // request tracking
  // the port may change while busy, so the taken request is kept
  assign idle = !pend || resp.valid;
  assign immv = ({24'h0, held.instr[7:0]} >> (2 * held.instr[11:8]))
              | ({24'h0, held.instr[7:0]} << (32 - 2 * held.instr[11:8]));
  always_ff @(posedge clk) begin
    if (srst) pend <= 1'b0;
    else if (idle && req.valid) pend <= 1'b1;
    else if (resp.valid) pend <= 1'b0;
    cnt <= (idle && req.valid) ? 3'h1 : cnt + 3'h1;
    if (idle && req.valid) held <= req;
  end
  // ===============================================
  // properties
  AST_ANSWER_BOUND: assert property (
    idle && req.valid |=> ##[0:5] resp.valid)
    else $error("no answer within six cycles");
  AST_COST_LATENCY: assert property (
    resp.valid && resp.decode_ok |-> pend && resp.cycles == cnt)
    else $error("answer latency differs from cost");
  AST_SHIFT_ZERO: assert property (
    resp.valid && resp.decode_ok && !held.instr[25] && held.instr[3:0] != 4'hf &&
    (held.instr[4] ? held.shift_amount_register[7:0] == 8'h00 : held.instr[11:5] == 7'h00)
    |-> resp.operand2 == held.shift_source_register &&
        resp.shifter_carry == held.current_status_register[CARRY_BIT])
    else $error("zero shift lost source or carry");
  AST_IMM_VALUE: assert property (
    resp.valid && resp.decode_ok && held.instr[25] |-> resp.operand2 == immv)
    else $error("rotated immediate wrong");
  AST_TEST_FLAG: assert property (
    resp.valid && held.instr[24:23] == 2'b10 && !held.instr[20] |-> !resp.decode_ok)
    else $error("test opcode without flag bit accepted");
  AST_RESTORE: assert property (
    resp.valid && resp.status_restore |->
    resp.pc_write && next_status == held.saved_status_register)
    else $error("status restore wrong");
  AST_PC_LOW: assert property (
    resp.valid && resp.pc_write |-> pc_value == {resp.operand2[31:2], 2'h0})
    else $error("pc low bits not cleared");
  AST_PC_OPERAND: assert property (
    resp.valid && resp.decode_ok && held.instr[19:16] == PC_REG_NUM |->
    resp.operand1 == ((held.instr_addr + PC_OFFSET) & PC_LOW_MASK))
    else $error("pc operand offset wrong");
  AST_CARRY_LOAD: assert property (
    resp.valid && resp.load_carry |->
    !resp.pc_write && next_status[CARRY_BIT] == resp.shifter_carry)
    else $error("carry load wrong");
endmodule : opshift_chk

bind operand_shifter_datapath opshift_chk opshift_chk_i (.clk(clk), .srst(srst), .req(req),
  .resp(resp), .next_status(next_status), .pc_value(pc_value));

// file: tb/pipe_partner.sv
// pipeline model that issues decode requests to the datapath
`timescale 1ns/1ps
module pipe_partner (
  // clock
  input  wire logic                  clk,
  // request toward the datapath
  output opshift_pkg::dp_req_t       req,
  // answer from the datapath
  input  wire opshift_pkg::dp_resp_t resp
);
  import opshift_pkg::*;
  initial req = '0;
  // ===============================================
  // issue and release
  // released lines show inverted data so stale values never pass for live ones
  task automatic release_bus();
    dp_req_t t;
    t = ~req;
    t.valid = 1'b0;
    req = t;
  endtask : release_bus

  // valid stands for the taking edge only; held longer it could be taken twice
  task automatic issue(input dp_req_t r, output int lat);
    dp_req_t t;
    t = r;
    t.valid = 1'b1;
    req = t;
    lat = 1;
    @(posedge clk);
    #1;
    if (resp.valid !== 1'b1) release_bus();
    while (resp.valid !== 1'b1 && lat < 8) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask : issue
endmodule : pipe_partner
